// [core/eie_consts.svh]
// constants for the extended instruction execute block
// assumes a byte-wide data memory and a 16-bit program word
`ifndef EIE_CONSTS_SVH
`define EIE_CONSTS_SVH
`define EIE_BYTE_W      8
`define EIE_NIB_W       4
`define EIE_WORD_W      16
`define EIE_BIT_SEL_W   3
`define EIE_ZERO_BYTE   8'h00
`define EIE_ACC_RST     8'h00
`define EIE_TABLE_POINTER_LOW_RST    8'h00
`define EIE_TABLE_READ_HIGH_LATCH_RST    8'h00
`define EIE_CLK_PERIOD_NS 4
// a skipping instruction takes three instruction cycles, others two
`define EIE_CYC_NORMAL  2
`define EIE_CYC_SKIP    3
`endif

// [core/eie_pkg.sv]
// types shared by the extended instruction execute block
// assumes the includer also pulls in eie_consts.svh
package eie_pkg;

  typedef enum logic [3:0] {
    EIE_OP_NONE         = 4'b0000,
    EIE_OP_SUBM         = 4'b0001, // sub_to_memory_ext
    EIE_OP_NIBM         = 4'b0010, // nibble_exchange_mem
    EIE_OP_NIBA         = 4'b0011, // nibble_exchange_to_acc
    EIE_OP_SKZ          = 4'b0100, // skip_on_zero_ext
    EIE_OP_MVSKZ        = 4'b0101, // move_and_skip_on_zero
    EIE_OP_SKZ_BIT      = 4'b0110, // bit form of skip_on_zero_ext
    EIE_OP_TRD          = 4'b0111, // paged_table_read
    EIE_OP_TRDL         = 4'b1000, // last_page_table_read
    EIE_OP_ITRD         = 4'b1001, // inc_paged_table_read
    EIE_OP_ITRDL        = 4'b1010, // inc_last_page_table_read
    EIE_OP_XORA         = 4'b1011, // xor_to_accumulator_ext
    EIE_OP_XORM         = 4'b1100  // xor_to_memory_ext
  } eie_op_t;

  typedef enum logic [1:0] {
    EIE_ST_IDLE  = 2'b00,
    EIE_ST_FETCH = 2'b01,
    EIE_ST_WRITE = 2'b10,
    EIE_ST_DUMMY = 2'b11
  } eie_state_t;

  typedef struct packed {
    logic ov; // arith_range_error_flag
    logic z;
    logic ac; // half_byte_carry_flag
    logic c;
    logic sc; // signed_chain_flag
    logic cz; // carry_zero_chain_flag
  } eie_flags_t;

  typedef struct packed {
    eie_op_t    op;
    logic [2:0] bit_sel;
  } eie_instr_t;

endpackage

// [core/eie_exec.sv]
// execution unit for a subset of extended-address instructions
// assumes the core presents the operand byte with the instruction and applies mem writes itself
`timescale 1ns/1ps
`include "eie_consts.svh"

module eie_exec #(
  parameter int PM_AW = 12
) (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  // instruction issue
  input  wire logic                         instr_valid,
  input  wire eie_pkg::eie_instr_t          instr,
  input  wire logic [`EIE_BYTE_W-1:0]       mem_rdata,
  output logic                              instr_ready,
  // data memory write-back
  output logic                              mem_we,
  output logic [`EIE_BYTE_W-1:0]            mem_wdata,
  // program memory table port, data valid the cycle after pm_rd
  output logic                              pm_rd,
  output logic [PM_AW-1:0]                  pm_addr,
  input  wire logic [`EIE_WORD_W-1:0]       pm_rdata,
  // core state loads
  input  wire logic                         acc_we,
  input  wire logic [`EIE_BYTE_W-1:0]       acc_wdata,
  input  wire logic                         table_pointer_low_we,
  input  wire logic [`EIE_BYTE_W-1:0]       table_pointer_low_wdata,
  input  wire logic [`EIE_BYTE_W-1:0]       table_pointer_high,
  // visible state
  output logic [`EIE_BYTE_W-1:0]            acc,
  output eie_pkg::eie_flags_t               flags,
  output logic [`EIE_BYTE_W-1:0]            table_pointer_low,
  output logic [`EIE_BYTE_W-1:0]            table_read_high_latch,
  output logic                              skip_dummy,
  output logic                              instr_done
);

  localparam int PG_W = PM_AW - `EIE_BYTE_W;

  eie_pkg::eie_state_t          state_reg;
  eie_pkg::eie_op_t             op_reg;
  logic [2:0]                   bit_reg;
  logic [`EIE_BYTE_W-1:0]       opnd_reg;
  logic [`EIE_BYTE_W-1:0]       acc_reg;
  eie_pkg::eie_flags_t          flags_reg;
  logic [`EIE_BYTE_W-1:0]       table_pointer_low_reg;
  logic [`EIE_BYTE_W-1:0]       table_read_high_latch_reg;
  logic                         mem_we_reg;
  logic [`EIE_BYTE_W-1:0]       mem_wdata_reg;
  logic                         pm_rd_reg;
  logic [PM_AW-1:0]             pm_addr_reg;
  logic                         skip_reg;
  logic                         done_reg;

  logic                         accept;
  logic                         is_inc;
  logic                         is_last;
  logic [`EIE_BYTE_W-1:0]       table_pointer_low_next;
  logic [`EIE_BYTE_W:0]         diff;
  logic [`EIE_BYTE_W-1:0]       xor_res;
  logic [`EIE_BYTE_W-1:0]       swapped;
  logic                         skip_take;

  assign instr_ready = (state_reg == eie_pkg::EIE_ST_IDLE);
  assign accept      = instr_valid && instr_ready;
  assign is_inc      = (instr.op == eie_pkg::EIE_OP_ITRD) || (instr.op == eie_pkg::EIE_OP_ITRDL);
  assign is_last     = (instr.op == eie_pkg::EIE_OP_TRDL) || (instr.op == eie_pkg::EIE_OP_ITRDL);
  // pointer low is bumped before the address is formed
  assign table_pointer_low_next   = is_inc ? table_pointer_low_reg + 8'h01 : table_pointer_low_reg;

  // 9-bit difference: the borrow lands in bit 8, so carry is its inverse
  assign diff    = {1'b0, acc_reg} - {1'b0, opnd_reg};
  assign xor_res = acc_reg ^ opnd_reg;
  assign swapped = {opnd_reg[`EIE_NIB_W-1:0], opnd_reg[`EIE_BYTE_W-1:`EIE_NIB_W]};

  always_comb begin
    case (op_reg)
      eie_pkg::EIE_OP_SKZ, eie_pkg::EIE_OP_MVSKZ: skip_take = (opnd_reg == `EIE_ZERO_BYTE);
      eie_pkg::EIE_OP_SKZ_BIT:                    skip_take = ~opnd_reg[bit_reg];
      default:                                    skip_take = 1'b0;
    endcase
  end

  // sequencing: issue -> fetch -> write -> optional dummy
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= eie_pkg::EIE_ST_IDLE;
    end else begin
      case (state_reg)
        eie_pkg::EIE_ST_IDLE:  if (accept) state_reg <= eie_pkg::EIE_ST_FETCH;
        eie_pkg::EIE_ST_FETCH: state_reg <= eie_pkg::EIE_ST_WRITE;
        eie_pkg::EIE_ST_WRITE: state_reg <= skip_take ? eie_pkg::EIE_ST_DUMMY : eie_pkg::EIE_ST_IDLE;
        eie_pkg::EIE_ST_DUMMY: state_reg <= eie_pkg::EIE_ST_IDLE;
        default:               state_reg <= eie_pkg::EIE_ST_IDLE;
      endcase
    end
  end

  // instruction latch; operand is sampled at issue only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      op_reg   <= eie_pkg::EIE_OP_NONE;
      bit_reg  <= 3'h0;
      opnd_reg <= `EIE_ZERO_BYTE;
    end else if (accept) begin
      op_reg   <= instr.op;
      bit_reg  <= instr.bit_sel;
      opnd_reg <= mem_rdata;
    end
  end

  // table pointer low: core load loses to an incrementing read in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      table_pointer_low_reg <= `EIE_TABLE_POINTER_LOW_RST;
    end else if (accept && is_inc) begin
      table_pointer_low_reg <= table_pointer_low_next;
    end else if (table_pointer_low_we) begin
      table_pointer_low_reg <= table_pointer_low_wdata;
    end
  end

  // program memory request, one cycle after issue
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pm_rd_reg   <= 1'b0;
      pm_addr_reg <= '0;
    end else begin
      pm_rd_reg <= accept && (instr.op inside {eie_pkg::EIE_OP_TRD, eie_pkg::EIE_OP_TRDL,
                                               eie_pkg::EIE_OP_ITRD, eie_pkg::EIE_OP_ITRDL});
      if (accept) begin
        if (is_last)
          pm_addr_reg <= {{PG_W{1'b1}}, table_pointer_low_next};
        else
          pm_addr_reg <= {table_pointer_high[PG_W-1:0], table_pointer_low_next};
      end
    end
  end

  // memory write-back, issued at the end of the write cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mem_we_reg    <= 1'b0;
      mem_wdata_reg <= `EIE_ZERO_BYTE;
    end else if (state_reg == eie_pkg::EIE_ST_WRITE) begin
      mem_we_reg <= 1'b1;
      case (op_reg)
        eie_pkg::EIE_OP_SUBM:                      mem_wdata_reg <= diff[`EIE_BYTE_W-1:0];
        eie_pkg::EIE_OP_NIBM:                      mem_wdata_reg <= swapped;
        eie_pkg::EIE_OP_SKZ:                       mem_wdata_reg <= opnd_reg;
        eie_pkg::EIE_OP_XORM:                      mem_wdata_reg <= xor_res;
        eie_pkg::EIE_OP_TRD, eie_pkg::EIE_OP_TRDL,
        eie_pkg::EIE_OP_ITRD, eie_pkg::EIE_OP_ITRDL: mem_wdata_reg <= pm_rdata[`EIE_BYTE_W-1:0];
        default: begin
          mem_we_reg    <= 1'b0;
          mem_wdata_reg <= mem_wdata_reg;
        end
      endcase
    end else begin
      mem_we_reg <= 1'b0;
    end
  end

  // table-high latch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      table_read_high_latch_reg <= `EIE_TABLE_READ_HIGH_LATCH_RST;
    end else if (state_reg == eie_pkg::EIE_ST_WRITE && op_reg inside {eie_pkg::EIE_OP_TRD,
                 eie_pkg::EIE_OP_TRDL, eie_pkg::EIE_OP_ITRD, eie_pkg::EIE_OP_ITRDL}) begin
      table_read_high_latch_reg <= pm_rdata[`EIE_WORD_W-1:`EIE_BYTE_W];
    end
  end

  // accumulator: an instruction result wins over a core load in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_reg <= `EIE_ACC_RST;
    end else if (state_reg == eie_pkg::EIE_ST_WRITE && op_reg == eie_pkg::EIE_OP_NIBA) begin
      acc_reg <= swapped;
    end else if (state_reg == eie_pkg::EIE_ST_WRITE && op_reg == eie_pkg::EIE_OP_MVSKZ) begin
      acc_reg <= opnd_reg;
    end else if (state_reg == eie_pkg::EIE_ST_WRITE && op_reg == eie_pkg::EIE_OP_XORA) begin
      acc_reg <= xor_res;
    end else if (acc_we) begin
      acc_reg <= acc_wdata;
    end
  end

  // flags: only subtract and the two xors touch them
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flags_reg <= '0;
    end else if (state_reg == eie_pkg::EIE_ST_WRITE) begin
      case (op_reg)
        eie_pkg::EIE_OP_SUBM: begin
          flags_reg.c  <= ~diff[`EIE_BYTE_W];
          flags_reg.ac <= (acc_reg[`EIE_NIB_W-1:0] >= opnd_reg[`EIE_NIB_W-1:0]);
          flags_reg.z  <= (diff[`EIE_BYTE_W-1:0] == `EIE_ZERO_BYTE);
          flags_reg.ov <= (acc_reg[7] ^ opnd_reg[7]) & (acc_reg[7] ^ diff[7]);
          flags_reg.sc <= ((acc_reg[7] ^ opnd_reg[7]) & (acc_reg[7] ^ diff[7])) ^ diff[7];
          flags_reg.cz <= (diff[`EIE_BYTE_W-1:0] == `EIE_ZERO_BYTE);
        end
        eie_pkg::EIE_OP_XORA, eie_pkg::EIE_OP_XORM: flags_reg.z <= (xor_res == `EIE_ZERO_BYTE);
        default: flags_reg <= flags_reg;
      endcase
    end
  end

  // skip and completion indications
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      skip_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      skip_reg <= (state_reg == eie_pkg::EIE_ST_WRITE) && skip_take;
      done_reg <= ((state_reg == eie_pkg::EIE_ST_WRITE) && !skip_take) ||
                  (state_reg == eie_pkg::EIE_ST_DUMMY);
    end
  end

  assign mem_we                = mem_we_reg;
  assign mem_wdata             = mem_wdata_reg;
  assign pm_rd                 = pm_rd_reg;
  assign pm_addr               = pm_addr_reg;
  assign acc                   = acc_reg;
  assign flags                 = flags_reg;
  assign table_pointer_low     = table_pointer_low_reg;
  assign table_read_high_latch = table_read_high_latch_reg;
  assign skip_dummy            = skip_reg;
  assign instr_done            = done_reg;

  chk_subm_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == eie_pkg::EIE_ST_WRITE && op_reg == eie_pkg::EIE_OP_SUBM) |=>
      mem_we && mem_wdata == $past(acc_reg - opnd_reg) && flags.c == ($past(acc_reg) >= $past(opnd_reg)))
    else $error("subtract to memory wrong");

  chk_nibm_swap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == eie_pkg::EIE_ST_WRITE && op_reg == eie_pkg::EIE_OP_NIBM) |=>
      mem_we && mem_wdata == {$past(opnd_reg[3:0]), $past(opnd_reg[7:4])} && $stable(flags))
    else $error("in place nibble swap wrong");

  chk_niba_acc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == eie_pkg::EIE_ST_WRITE && op_reg == eie_pkg::EIE_OP_NIBA) |=>
      !mem_we && acc == {$past(opnd_reg[3:0]), $past(opnd_reg[7:4])} && $stable(flags))
    else $error("nibble swap to acc wrong");

  chk_skz_skip: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (accept && instr.op == eie_pkg::EIE_OP_SKZ && mem_rdata == 8'h00) |-> ##3 skip_dummy && mem_we
      && mem_wdata == 8'h00)
    else $error("zero test did not skip");

  chk_skip_three: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == eie_pkg::EIE_ST_WRITE && skip_take) |=> state_reg == eie_pkg::EIE_ST_DUMMY ##1
      instr_ready && instr_done)
    else $error("skip not three cycles");

  chk_mvskz_acc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (accept && instr.op == eie_pkg::EIE_OP_MVSKZ) |-> ##3 acc == $past(mem_rdata, 3)
      && skip_dummy == ($past(mem_rdata, 3) == 8'h00))
    else $error("move and test wrong");

  chk_bit_skip: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == eie_pkg::EIE_ST_WRITE && op_reg == eie_pkg::EIE_OP_SKZ_BIT) |=>
      skip_dummy == !$past(opnd_reg[bit_reg]) && $stable(flags))
    else $error("bit test skip wrong");

  chk_tbl_paged: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (accept && instr.op == eie_pkg::EIE_OP_TRD) |=> pm_rd
      && pm_addr == {table_pointer_high[PG_W-1:0], table_pointer_low} ##2 table_read_high_latch == $past(pm_rdata[15:8]))
    else $error("paged table read wrong");

  chk_tbl_last: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (accept && instr.op == eie_pkg::EIE_OP_TRDL) |=> pm_rd && pm_addr[PM_AW-1:8] == {PG_W{1'b1}})
    else $error("last page address wrong");

  chk_tbl_inc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (accept && is_inc) |=> table_pointer_low == $past(table_pointer_low_reg) + 8'h01
      && pm_addr[7:0] == table_pointer_low)
    else $error("pointer not incremented first");

  chk_xor_acc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == eie_pkg::EIE_ST_WRITE && op_reg == eie_pkg::EIE_OP_XORA) |=>
      acc == $past(xor_res) && flags.z == (acc == 8'h00) && flags.c == $past(flags_reg.c))
    else $error("xor to acc wrong");

  chk_xor_mem: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == eie_pkg::EIE_ST_WRITE && op_reg == eie_pkg::EIE_OP_XORM) |=>
      mem_we && mem_wdata == $past(xor_res) && flags.z == (mem_wdata == 8'h00))
    else $error("xor to memory wrong");

  chk_dummy_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == eie_pkg::EIE_ST_DUMMY && !acc_we && !table_pointer_low_we) |=>
      !mem_we && $stable(acc) && $stable(flags) && $stable(table_pointer_low))
    else $error("dummy cycle changed state");

endmodule // eie_exec

// [bench/tb.sv]
// self-checking bench for eie_exec: drives every op through its ports and checks the results
// assumes eie_pkg is compiled first; program words are driven from the negedge of the pm_rd cycle through the cycle after
`timescale 1ns/1ps
`include "eie_consts.svh"

module tb;
  localparam int PM_AW = 12;

  logic                   clk_sys = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   instr_valid = 1'b0;
  eie_pkg::eie_instr_t    instr = '0;
  logic [7:0]             mem_rdata = 8'h00;
  logic                   instr_ready;
  logic                   mem_we;
  logic [7:0]             mem_wdata;
  logic                   pm_rd;
  logic [PM_AW-1:0]       pm_addr;
  logic [15:0]            pm_rdata = 16'h0000;
  logic                   acc_we = 1'b0;
  logic [7:0]             acc_wdata = 8'h00;
  logic                   table_pointer_low_we = 1'b0;
  logic [7:0]             table_pointer_low_wdata = 8'h00;
  logic [7:0]             table_pointer_high = 8'hA5;
  logic [7:0]             acc;
  eie_pkg::eie_flags_t    flags;
  logic [7:0]             table_pointer_low;
  logic [7:0]             table_read_high_latch;
  logic                   skip_dummy;
  logic                   instr_done;
  int                     failures = 0;
  int                     compares = 0;
  // observations of the last instruction
  logic                   saw_we, saw_skip, saw_pm;
  logic [7:0]             wd, apre;
  logic [PM_AW-1:0]       pa;
  logic [5:0]             fpre;
  int                     cycles;

  always #(`EIE_CLK_PERIOD_NS / 2.0) clk_sys = ~clk_sys;

  eie_exec #(.PM_AW(PM_AW)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr), .mem_rdata(mem_rdata),
    .instr_ready(instr_ready), .mem_we(mem_we), .mem_wdata(mem_wdata), .pm_rd(pm_rd), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .acc_we(acc_we), .acc_wdata(acc_wdata), .table_pointer_low_we(table_pointer_low_we), .table_pointer_low_wdata(table_pointer_low_wdata),
    .table_pointer_high(table_pointer_high), .acc(acc), .flags(flags), .table_pointer_low(table_pointer_low),
    .table_read_high_latch(table_read_high_latch), .skip_dummy(skip_dummy), .instr_done(instr_done)
  );

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic load(input logic to_acc, input logic [7:0] v);
    @(negedge clk_sys);
    if (to_acc) begin acc_we = 1'b1; acc_wdata = v; end
    else begin table_pointer_low_we = 1'b1; table_pointer_low_wdata = v; end
    @(negedge clk_sys);
    acc_we = 1'b0;
    table_pointer_low_we = 1'b0;
  endtask

  // issue one op; operand is scrambled after the accept edge to catch late sampling
  task automatic run(input eie_pkg::eie_op_t op, input logic [2:0] bs, input logic [7:0] m, input logic [15:0] pmw);
    logic       hold;
    logic [7:0] a0, p0;
    logic [5:0] f0;
    @(negedge clk_sys);
    apre = acc;
    fpre = flags;
    instr_valid = 1'b1;
    instr = '{op: op, bit_sel: bs};
    mem_rdata = m;
    @(posedge clk_sys);
    @(negedge clk_sys);
    instr_valid = 1'b0;
    mem_rdata = ~m;
    {saw_we, saw_skip, saw_pm, hold} = 4'h0;
    cycles = 1;
    while (instr_done !== 1'b1 && cycles < 10) begin
      chk(instr_ready, 1'b0);
      if (mem_we === 1'b1) begin saw_we = 1'b1; wd = mem_wdata; end
      if (pm_rd === 1'b1) begin saw_pm = 1'b1; pa = pm_addr; end
      if (skip_dummy === 1'b1) begin saw_skip = 1'b1; a0 = acc; f0 = flags; p0 = table_pointer_low; end
      pm_rdata = (pm_rd === 1'b1 || hold) ? pmw : ~pmw;
      hold = (pm_rd === 1'b1);
      @(negedge clk_sys);
      cycles++;
    end
    if (cycles >= 10) begin
      // a hang is reported as a mismatch before the run is closed
      chk(16'(cycles), 16'h0004);
      end_sim();
    end
    if (saw_skip) begin
      chk(mem_we, 1'b0);
      chk(acc, a0);
      chk(16'(flags), f0);
      chk(table_pointer_low, p0);
    end else if (mem_we === 1'b1) begin
      saw_we = 1'b1;
      wd = mem_wdata;
    end
  endtask

  // common judgement of the skipping family: no flag change, cycle count follows the skip
  task automatic skip_chk(input logic exp_skip, input logic exp_we);
    chk(saw_skip, exp_skip);
    chk(16'(cycles), exp_skip ? 16'h0004 : 16'h0003);
    chk(saw_we, exp_we);
    chk(16'(flags), fpre);
  endtask

  task automatic t_sub;
    logic [7:0] pa_t[4] = '{8'h05, 8'h00, 8'h33, 8'h80};
    logic [7:0] pb_t[4] = '{8'h07, 8'hFF, 8'h33, 8'h01};
    logic [7:0] r;
    logic       ov;
    for (int i = 0; i < 4; i++) begin
      load(1'b1, pa_t[i]);
      run(eie_pkg::EIE_OP_SUBM, 3'h0, pb_t[i], 16'h0000);
      r = pa_t[i] - pb_t[i];
      ov = (pa_t[i][7] != pb_t[i][7]) && (r[7] != pa_t[i][7]);
      chk(saw_we, 1'b1);
      chk(wd, r);
      chk(acc, pa_t[i]);
      chk(16'(flags), {ov, r == 8'h00, pa_t[i][3:0] >= pb_t[i][3:0], pa_t[i] >= pb_t[i], ov ^ r[7],
                       r == 8'h00});
    end
    $display("test sub_to_memory_ext done");
  endtask

  task automatic t_nib;
    run(eie_pkg::EIE_OP_NIBM, 3'h0, 8'h3C, 16'h0000);
    chk(wd, 8'hC3);
    chk(16'(flags), fpre);
    chk(acc, apre);
    run(eie_pkg::EIE_OP_NIBA, 3'h0, 8'hA5, 16'h0000);
    chk(acc, 8'h5A);
    chk(saw_we, 1'b0);
    chk(16'(flags), fpre);
    $display("test nibble exchange done");
  endtask

  task automatic t_skip;
    run(eie_pkg::EIE_OP_SKZ, 3'h0, 8'h00, 16'h0000);
    skip_chk(1'b1, 1'b1);
    chk(wd, 8'h00);
    run(eie_pkg::EIE_OP_SKZ, 3'h0, 8'h10, 16'h0000);
    skip_chk(1'b0, 1'b1);
    chk(wd, 8'h10);
    run(eie_pkg::EIE_OP_MVSKZ, 3'h0, 8'h00, 16'h0000);
    skip_chk(1'b1, 1'b0);
    chk(acc, 8'h00);
    run(eie_pkg::EIE_OP_MVSKZ, 3'h0, 8'h80, 16'h0000);
    skip_chk(1'b0, 1'b0);
    chk(acc, 8'h80);
    for (int b = 0; b < 8; b++) begin
      run(eie_pkg::EIE_OP_SKZ_BIT, 3'(b), 8'hFF ^ (8'h01 << b), 16'h0000);
      skip_chk(1'b1, 1'b0);
      run(eie_pkg::EIE_OP_SKZ_BIT, 3'(b), 8'h01 << b, 16'h0000);
      skip_chk(1'b0, 1'b0);
    end
    $display("test skips done");
  endtask

  task automatic t_table;
    eie_pkg::eie_op_t  ops[4] = '{eie_pkg::EIE_OP_TRD, eie_pkg::EIE_OP_TRDL, eie_pkg::EIE_OP_ITRD,
                                  eie_pkg::EIE_OP_ITRDL};
    logic [15:0]       w[4] = '{16'h9A31, 16'h5CE2, 16'hE407, 16'h2B7F};
    logic [7:0]        tp[4] = '{8'hFF, 8'hFF, 8'h00, 8'h01};
    logic              last;
    load(1'b0, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      run(ops[i], 3'h0, 8'h00, w[i]);
      last = (i % 2) == 1;
      chk(table_pointer_low, tp[i]);
      chk(saw_pm, 1'b1);
      chk(16'(pa), last ? 16'({{(PM_AW - 8){1'b1}}, tp[i]}) :
                          16'({table_pointer_high[PM_AW-9:0], tp[i]}));
      chk(saw_we, 1'b1);
      chk(wd, w[i][7:0]);
      chk(table_read_high_latch, w[i][15:8]);
      chk(16'(flags), fpre);
    end
    $display("test table reads done");
  endtask

  task automatic t_xor;
    load(1'b1, 8'h5A);
    run(eie_pkg::EIE_OP_XORA, 3'h0, 8'h5A, 16'h0000);
    chk(acc, 8'h00);
    chk(saw_we, 1'b0);
    chk(16'(flags), {fpre[5], 1'b1, fpre[3:0]});
    load(1'b1, 8'h0F);
    run(eie_pkg::EIE_OP_XORM, 3'h0, 8'hF0, 16'h0000);
    chk(wd, 8'hFF);
    chk(acc, 8'h0F);
    chk(16'(flags), {fpre[5], 1'b0, fpre[3:0]});
    $display("test exclusive-or done");
  endtask

  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    chk(instr_ready, 1'b1);
    chk(acc, 8'h00);
    chk(table_read_high_latch, 8'h00);
    t_sub();
    t_nib();
    t_skip();
    t_table();
    t_xor();
    end_sim();
  end
endmodule // tb
